// ### src/aisr_top.sv
// Converter input select and reference control registers with registered analog controls
// Function
// - Codes 0x00-0x1f route port pins ascending
// - Temp sensor, supply, ground, reserved codes
// - Temp sensor reached only through input mux
// - Temp sensor powered only while enabled
// - Reference select: pin or supply
// - Bias auto-on for converter, sensor, oscillator
// - Bias enable bit forces bias on
// - Buffer enable drives reference onto pin
// - Reference level selectable between two settings
// - Reference control bit layout, resets zero
// - Level bit: 0 low, 1 high
`timescale 1ns/10ps
`include "aisr_consts.svh"
module aisr_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  // Peripheral status and conversion start
  input wire logic adcEnable,
  input wire logic oscEnable,
  input wire logic convStart,
  // Input multiplexer controls
  output logic muxPinEn,
  output logic [4:0] muxPinIdx,
  output logic muxTempEn,
  output logic muxVddEn,
  output logic muxGndEn,
  output logic [5:0] sampledSel,
  output logic sampleMeaningful,
  // Reference and bias controls
  output logic tempSensorPower,
  output logic refUseVdd,
  output logic refBufferDrive,
  output logic refLevelHigh,
  output logic biasOn,
  output logic ztcBiasForce
);
  typedef struct packed {
    logic [5:0] chanSel;
    logic [5:0] refCtl;
    logic [7:0] rdData;
    logic pinEn;
    logic [4:0] pinIdx;
    logic tempEn;
    logic vddEn;
    logic gndEn;
    logic [5:0] sampled;
    logic meaningful;
    logic tempPwr;
    logic useVdd;
    logic bufDrive;
    logic levelHigh;
    logic bias;
    logic ztc;
  } aisr_state_s;

  aisr_state_s st;
  aisr_state_s next_st;
  aisr_pkg::aisr_src_e curKind;
  logic [4:0] curPinIdx;
  logic rstnMeta;
  logic rstnSync;

  // Release of reset is synchronised; assertion is immediate
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstnMeta <= 1'b0;
      rstnSync <= 1'b0;
    end
    else
    begin
      rstnMeta <= 1'b1;
      rstnSync <= rstnMeta;
    end
  end

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  aisr_chan_decode u_decode (
    .code(st.chanSel),
    .kind(curKind),
    .pinIdx(curPinIdx)
  );

  always_comb
  begin
    next_st = st;
    if (sfrWrEn && hit(sfrAddr, `AISR_CHAN_ADDR))
      next_st.chanSel = sfrWrData[5:0];
    if (sfrWrEn && hit(sfrAddr, `AISR_REF_ADDR))
      next_st.refCtl = sfrWrData[5:0];
    if (sfrRdEn)
    begin
      if (hit(sfrAddr, `AISR_CHAN_ADDR))
        next_st.rdData = {2'h0, st.chanSel};
      else if (hit(sfrAddr, `AISR_REF_ADDR))
        next_st.rdData = {2'h0, st.refCtl};
      else
        next_st.rdData = 8'h00;
    end
    // Mux controls follow the stored code one cycle later
    next_st.pinEn = (curKind == aisr_pkg::SRC_PIN);
    next_st.pinIdx = curPinIdx;
    next_st.tempEn = (curKind == aisr_pkg::SRC_TEMP);
    next_st.vddEn = (curKind == aisr_pkg::SRC_VDD);
    next_st.gndEn = (curKind == aisr_pkg::SRC_GND);
    if (convStart)
    begin
      next_st.sampled = st.chanSel;
      // Reserved codes and an unpowered sensor give no usable sample
      next_st.meaningful = (curKind != aisr_pkg::SRC_RSVD) &&
        !((curKind == aisr_pkg::SRC_TEMP) && !st.refCtl[`AISR_BIT_TEMP_SENSOR_ENABLE]);
    end
    next_st.tempPwr = st.refCtl[`AISR_BIT_TEMP_SENSOR_ENABLE];
    next_st.useVdd = st.refCtl[`AISR_BIT_REFSEL];
    next_st.bufDrive = st.refCtl[`AISR_BIT_REFBUF];
    next_st.levelHigh = st.refCtl[`AISR_BIT_LEVEL];
    next_st.bias = st.refCtl[`AISR_BIT_BIAS] | adcEnable | oscEnable |
      st.refCtl[`AISR_BIT_TEMP_SENSOR_ENABLE];
    next_st.ztc = st.refCtl[`AISR_BIT_ZTC];
  end

  always_ff @(posedge core_clk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      st <= '0;
      st.chanSel <= `AISR_CHAN_RST;
      st.refCtl <= `AISR_REF_RST;
      st.gndEn <= 1'b1;
      st.sampled <= `AISR_CHAN_RST;
      st.meaningful <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign sfrRdData = st.rdData;
  assign muxPinEn = st.pinEn;
  assign muxPinIdx = st.pinIdx;
  assign muxTempEn = st.tempEn;
  assign muxVddEn = st.vddEn;
  assign muxGndEn = st.gndEn;
  assign sampledSel = st.sampled;
  assign sampleMeaningful = st.meaningful;
  assign tempSensorPower = st.tempPwr;
  assign refUseVdd = st.useVdd;
  assign refBufferDrive = st.bufDrive;
  assign refLevelHigh = st.levelHigh;
  assign biasOn = st.bias;
  assign ztcBiasForce = st.ztc;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstnSync);

  sequence s_chan_wr_pin;
    sfrWrEn && hit(sfrAddr, `AISR_CHAN_ADDR) && (sfrWrData[5:0] <= `AISR_CODE_P3_0);
  endsequence

  sequence s_pin_seen;
    ##2 muxPinEn && !muxTempEn && !muxGndEn;
  endsequence

  property p_pin_route;
    s_chan_wr_pin |-> s_pin_seen and (##2 muxPinIdx == $past(sfrWrData[4:0], 2));
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin code not routed");

  property p_special_route;
    ##1 (muxTempEn == ($past(st.chanSel) == `AISR_CODE_TEMP)) &&
      (muxVddEn == ($past(st.chanSel) == `AISR_CODE_VDD)) &&
      (muxGndEn == ($past(st.chanSel) >= `AISR_CODE_GND_FIRST));
  endproperty
  a_special_route: assert property (p_special_route) else $error("special source wrong");

  property p_p3_hi;
    (st.chanSel > `AISR_CODE_P3_0) && (st.chanSel <= `AISR_CODE_P3_LAST) |=>
      muxPinEn && (muxPinIdx == $past(st.chanSel[4:0]));
  endproperty
  a_p3_hi: assert property (p_p3_hi) else $error("upper port 3 pin not routed");

  property p_chan_read;
    sfrRdEn && hit(sfrAddr, `AISR_CHAN_ADDR) |=>
      sfrRdData == {2'h0, $past(st.chanSel)};
  endproperty
  a_chan_read: assert property (p_chan_read) else $error("select readback wrong");

  property p_temp_only;
    muxTempEn |-> !muxPinEn && !muxVddEn && !muxGndEn;
  endproperty
  a_temp_only: assert property (p_temp_only) else $error("sensor shares mux");

  property p_temp_power;
    ##1 tempSensorPower == $past(st.refCtl[`AISR_BIT_TEMP_SENSOR_ENABLE]);
  endproperty
  a_temp_power: assert property (p_temp_power) else $error("sensor power wrong");

  property p_ref_bits;
    ##1 (refUseVdd == $past(st.refCtl[`AISR_BIT_REFSEL])) &&
      (refBufferDrive == $past(st.refCtl[`AISR_BIT_REFBUF])) &&
      (refLevelHigh == $past(st.refCtl[`AISR_BIT_LEVEL]));
  endproperty
  a_ref_bits: assert property (p_ref_bits) else $error("reference control wrong");

  property p_bias;
    adcEnable || oscEnable || st.refCtl[`AISR_BIT_TEMP_SENSOR_ENABLE] || st.refCtl[`AISR_BIT_BIAS]
      |=> biasOn;
  endproperty
  a_bias: assert property (p_bias) else $error("bias not on");

  property p_bias_off;
    !adcEnable && !oscEnable && (st.refCtl[2:1] == 2'h0) |=> !biasOn;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias on without cause");

  property p_buf_write;
    sfrWrEn && hit(sfrAddr, `AISR_REF_ADDR) |-> ##2 refBufferDrive == $past(sfrWrData[0], 2);
  endproperty
  a_buf_write: assert property (p_buf_write) else $error("buffer drive wrong");

  property p_ref_read;
    sfrRdEn && hit(sfrAddr, `AISR_REF_ADDR) |=> sfrRdData == {2'h0, $past(st.refCtl)};
  endproperty
  a_ref_read: assert property (p_ref_read) else $error("reference readback wrong");

  property p_sample;
    convStart |=> sampledSel == $past(st.chanSel);
  endproperty
  a_sample: assert property (p_sample) else $error("sample select wrong");
endmodule

// ### src/aisr_consts.svh
// Offsets, field positions, reset values and channel codes for the input select block
`ifndef AISR_CONSTS_SVH
`define AISR_CONSTS_SVH
`define AISR_CHAN_ADDR 8'hbb
`define AISR_REF_ADDR 8'hd1
`define AISR_CHAN_RST 6'h3f
`define AISR_REF_RST 6'h00
`define AISR_CODE_P3_0 6'h18
`define AISR_CODE_P3_LAST 6'h1f
`define AISR_CODE_TEMP 6'h30
`define AISR_CODE_VDD 6'h31
`define AISR_CODE_GND_FIRST 6'h32
`define AISR_HAS_P3_HI 1'b1
`define AISR_BIT_ZTC 5
`define AISR_BIT_LEVEL 4
`define AISR_BIT_REFSEL 3
`define AISR_BIT_TEMP_SENSOR_ENABLE 2
`define AISR_BIT_BIAS 1
`define AISR_BIT_REFBUF 0
`endif

// ### src/aisr_pkg.sv
// Types shared by the input select and reference control block
package aisr_pkg;
  typedef enum logic [4:0] {
    SRC_PIN = 5'h01,
    SRC_TEMP = 5'h02,
    SRC_VDD = 5'h04,
    SRC_GND = 5'h08,
    SRC_RSVD = 5'h10
  } aisr_src_e;
endpackage

// ### src/aisr_chan_decode.sv
// Decodes a positive input select code into a source kind and pin index
`timescale 1ns/10ps
`include "aisr_consts.svh"
module aisr_chan_decode (
  // Select code
  input wire logic [5:0] code,
  // Decoded source
  output aisr_pkg::aisr_src_e kind,
  output logic [4:0] pinIdx
);
  always_comb
  begin
    kind = aisr_pkg::SRC_RSVD;
    pinIdx = code[4:0];
    unique case (code[5:4])
      2'h0, 2'h1:
      begin
        if (code <= `AISR_CODE_P3_0)
          kind = aisr_pkg::SRC_PIN;
        else if (`AISR_HAS_P3_HI)
          kind = aisr_pkg::SRC_PIN;
        else
          kind = aisr_pkg::SRC_RSVD;
      end
      2'h2:
        kind = aisr_pkg::SRC_RSVD;
      2'h3:
      begin
        if (code == `AISR_CODE_TEMP)
          kind = aisr_pkg::SRC_TEMP;
        else if (code == `AISR_CODE_VDD)
          kind = aisr_pkg::SRC_VDD;
        else
          kind = aisr_pkg::SRC_GND;
      end
    endcase
  end
endmodule

// ### dv/adc_input_select_reference_control_tb.sv
// Self-checking bench for the converter input select and reference control block
`timescale 1ns/10ps
`include "aisr_consts.svh"
module adc_input_select_reference_control_tb;
  logic coreClk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrRdEn = 1'b0;
  logic [7:0] sfrRdData;
  logic adcEnable = 1'b0;
  logic oscEnable = 1'b0;
  logic convStart = 1'b0;
  logic muxPinEn, muxTempEn, muxVddEn, muxGndEn, sampleMeaningful;
  logic [4:0] muxPinIdx;
  logic [5:0] sampledSel;
  logic tempSensorPower, refUseVdd, refBufferDrive, refLevelHigh, biasOn, ztcBiasForce;
  logic [31:0] rngState = 32'h0000dcef;
  logic [5:0] chanReg = 6'h3f;
  logic [5:0] refReg = 6'h00;
  int failCount = 0;
  int checkCount = 0;

  aisr_top u_dut (.core_clk(coreClk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .adcEnable(adcEnable),
    .oscEnable(oscEnable), .convStart(convStart), .muxPinEn(muxPinEn), .muxPinIdx(muxPinIdx),
    .muxTempEn(muxTempEn), .muxVddEn(muxVddEn), .muxGndEn(muxGndEn), .sampledSel(sampledSel),
    .sampleMeaningful(sampleMeaningful), .tempSensorPower(tempSensorPower),
    .refUseVdd(refUseVdd), .refBufferDrive(refBufferDrive), .refLevelHigh(refLevelHigh),
    .biasOn(biasOn), .ztcBiasForce(ztcBiasForce));

  initial
  begin
    forever #5 coreClk = ~coreClk;
  end

  // Seed 56559
  function automatic logic [31:0] xorshift();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] expd);
    checkCount++;
    if (seen !== expd)
    begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge coreClk);
    sfrAddr = addr;
    sfrWrData = data;
    sfrWrEn = 1'b1;
    @(negedge coreClk);
    sfrWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] expd);
    @(negedge coreClk);
    sfrAddr = addr;
    sfrRdEn = 1'b1;
    @(negedge coreClk);
    sfrRdEn = 1'b0;
    chk(sfrRdData, expd);
  endtask

  // Expected mux, sample and reference outputs from the model registers
  task automatic chkOutputs(input logic adc, input logic osc);
    logic pin, temp, vdd, gnd, rsvd;
    pin = chanReg < 6'h20;
    temp = chanReg == 6'h30;
    vdd = chanReg == 6'h31;
    gnd = chanReg >= 6'h32;
    rsvd = chanReg[5:4] == 2'b10;
    chk({4'h0, muxPinEn, muxTempEn, muxVddEn, muxGndEn}, {4'h0, pin, temp, vdd, gnd});
    if (pin)
      chk({3'h0, muxPinIdx}, {3'h0, chanReg[4:0]});
    chk({2'h0, sampledSel}, {2'h0, chanReg});
    chk({7'h0, sampleMeaningful}, {7'h0, !rsvd && !(temp && !refReg[2])});
    chk({2'h0, ztcBiasForce, refLevelHigh, refUseVdd, tempSensorPower, 1'b0, refBufferDrive},
      {2'h0, refReg[5:2], 1'b0, refReg[0]});
    chk({7'h0, biasOn}, {7'h0, refReg[1] | refReg[2] | adc | osc});
  endtask

  task automatic step(input logic [5:0] code);
    logic [31:0] r;
    logic [7:0] xAddr;
    r = xorshift();
    xAddr = r[23:16] ^ 8'h40;
    wr(`AISR_CHAN_ADDR, {r[7:6], code});
    // Buffer kept off while the supply is the reference
    wr(`AISR_REF_ADDR, {r[15:9], r[8] & !r[11]});
    chanReg = code;
    refReg = {r[13:9], r[8] & !r[11]};
    // Stray write may still land on a mapped register
    wr(xAddr, r[31:24]);
    if (xAddr == `AISR_CHAN_ADDR)
      chanReg = r[29:24];
    if (xAddr == `AISR_REF_ADDR)
      refReg = r[29:24];
    @(negedge coreClk);
    adcEnable = r[24];
    oscEnable = r[25];
    convStart = 1'b1;
    @(negedge coreClk);
    convStart = 1'b0;
    @(negedge coreClk);
    chkOutputs(r[24], r[25]);
    rd(`AISR_CHAN_ADDR, {2'h0, chanReg});
    rd(`AISR_REF_ADDR, {2'h0, refReg});
    if ((xAddr != `AISR_CHAN_ADDR) && (xAddr != `AISR_REF_ADDR))
      rd(xAddr, 8'h00);
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    // Budget is well beyond the roughly fifteen hundred cycles the sequence needs
    #200000;
    failCount++;
    summarize();
  end

  initial
  begin
    repeat (16) @(negedge coreClk);
    rstn = 1'b1;
    repeat (3) @(negedge coreClk);
    chkOutputs(1'b0, 1'b0);
    rd(`AISR_CHAN_ADDR, 8'h3f);
    rd(`AISR_REF_ADDR, 8'h00);
    for (int i = 0; i < 64; i++)
      step(6'(i));
    for (int i = 0; i < 32; i++)
      step(6'(xorshift()));
    summarize();
  end
endmodule
